//--- hw/ssl_params.svh
// Constants of the safe speed limit monitor: offsets, fields, resets, timings.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
`ifndef SSL_PARAMS_SVH
`define SSL_PARAMS_SVH
`define SSL_CLK_HZ 25000000
`define SSL_TICK_US 1
`define SSL_TICK_CYC ((`SSL_CLK_HZ / 1000000) * `SSL_TICK_US)
`define SSL_OFS_CTRL 12'h000
`define SSL_OFS_STAT 12'h004
`define SSL_OFS_MASK 12'h008
`define SSL_OFS_CMD 12'h00c
`define SSL_OFS_FBK 12'h010
`define SSL_OFS_POS 12'h014
`define SSL_OFS_SPD_LIM1 12'h020
`define SSL_OFS_DEC_DLY1 12'h030
`define SSL_OFS_SPD_DLY 12'h040
`define SSL_OFS_POS_DLY 12'h044
`define SSL_OFS_POS_LIM 12'h048
`define SSL_OFS_SAFE_THR 12'h04c
`define SSL_OFS_SAFE_HYS 12'h050
`define SSL_OFS_STATE 12'h054
`define SSL_CTRL_STANDSTILL 0
`define SSL_CTRL_TRIP_CLR 1
`define SSL_EV_TRIP_SPD 0
`define SSL_EV_TRIP_POS 1
`define SSL_EV_SAFE_FALL 2
`define SSL_EV_SAFE_RISE 3
`define SSL_RST_LIMIT 16'hffff
`define SSL_RST_DELAY 16'h0064
`define SSL_RST_THR 16'h0000
`endif

//--- hw/ssl_pkg.sv
// Types shared by the safe speed limit monitor.
// Assumes nothing of its surroundings.
package ssl_pkg;
  typedef logic [15:0] ssl_word_t;
  typedef enum logic [1:0] {SSL_IDLE, SSL_DECEL, SSL_CHECK} ssl_req_state_t;
endpackage : ssl_pkg

//--- hw/ssl_persist.sv
// Persistence timer: flags when a condition has held for a set number of ticks.
// Assumes a one-cycle tick strobe from the caller.
`timescale 1ns/1ps
`default_nettype none
module ssl_persist (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic cond_i,
  input wire ssl_pkg::ssl_word_t delay_i,
  output logic expired_o
);
  import ssl_pkg::*;
  ssl_word_t cnt_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 16'h0000;
    end else if (!cond_i) begin
      cnt_r <= 16'h0000;
    end else if (tick_i && cnt_r < delay_i) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  assign expired_o = cond_i && (cnt_r >= delay_i);
endmodule : ssl_persist
`default_nettype wire

//--- hw/ssl_monitor.sv
// Safe speed limit monitor with APB registers and one interrupt line.
// Assumes APB from a single master; speed and position samples are synchronous inputs.
`timescale 1ns/1ps
`default_nettype none
`include "ssl_params.svh"
module ssl_monitor (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [3:0] limit_request_n_i,
  input wire logic signed [15:0] speed_cmd_i,
  input wire logic signed [15:0] speed_fbk_i,
  input wire logic signed [15:0] position_i,
  output logic torque_cutoff_trip_o,
  output logic safe_speed_status_out_o,
  output logic safe_brake_control_out_o,
  output logic irq_o
);
  import ssl_pkg::*;

  function automatic ssl_word_t mag(input logic signed [15:0] v);
    mag = v[15] ? ssl_word_t'(-v) : ssl_word_t'(v);
  endfunction : mag

  ssl_word_t spd_lim_r [4];
  ssl_word_t dec_dly_r [4];
  ssl_word_t spd_dly_r, pos_dly_r, pos_lim_r, safe_thr_r, safe_hys_r;
  logic [1:0] ctrl_r;
  logic [3:0] stat_r, mask_r;
  ssl_req_state_t req_st_r [4];
  ssl_word_t dec_cnt_r [4];
  logic [4:0] tick_cnt_r;
  logic tick_r;
  logic trip_r, safe_r;
  logic signed [15:0] pos_ref_r;
  logic standstill_d_r;
  ssl_word_t cmd_mag, fbk_mag, eff_lim, pos_dev;
  logic checking, cmd_exc, fbk_exc, cmd_exp, fbk_exp, pos_exc, pos_exp;
  logic bus_wr, bus_rd, addr_ok, trip_set;
  logic [3:0] ev;
  logic [31:0] rd_nxt;
  logic signed [16:0] pos_diff;

  assign bus_wr = psel_i && penable_i && pwrite_i;
  assign bus_rd = psel_i && !penable_i && !pwrite_i;

  // Tick strobe of one microsecond for every delay timer.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_r <= 5'h00;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 5'(`SSL_TICK_CYC - 1)) begin
      tick_cnt_r <= 5'h00;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 5'h01;
      tick_r <= 1'b0;
    end
  end

  assign cmd_mag = mag(speed_cmd_i);
  assign fbk_mag = mag(speed_fbk_i);

  // Per-request supervision: each request runs its own decel delay.
  for (genvar g = 0; g < 4; g++) begin : g_req
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        req_st_r[g] <= SSL_IDLE;
        dec_cnt_r[g] <= 16'h0000;
      end else begin
        case (req_st_r[g])
          SSL_IDLE: begin
            dec_cnt_r[g] <= 16'h0000;
            if (!limit_request_n_i[g]) begin
              req_st_r[g] <= SSL_DECEL;
            end
          end
          SSL_DECEL: begin
            if (limit_request_n_i[g]) begin
              req_st_r[g] <= SSL_IDLE;
            end else if (dec_cnt_r[g] >= dec_dly_r[g]) begin
              req_st_r[g] <= SSL_CHECK;
            end else if (tick_r) begin
              dec_cnt_r[g] <= dec_cnt_r[g] + 16'h0001;
            end
          end
          SSL_CHECK: begin
            if (limit_request_n_i[g]) begin
              req_st_r[g] <= SSL_IDLE;
            end
          end
          default: req_st_r[g] <= SSL_IDLE;
        endcase
      end
    end
  end

  // Smallest limit among the requests that are checking.
  always_comb begin
    eff_lim = `SSL_RST_LIMIT;
    checking = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (req_st_r[i] == SSL_CHECK) begin
        checking = 1'b1;
        if (spd_lim_r[i] < eff_lim) begin
          eff_lim = spd_lim_r[i];
        end
      end
    end
  end

  assign cmd_exc = checking && (cmd_mag > eff_lim);
  assign fbk_exc = checking && (fbk_mag > eff_lim);

  ssl_persist u_cmd (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .tick_i(tick_r),
    .cond_i(cmd_exc),
    .delay_i(spd_dly_r),
    .expired_o(cmd_exp)
  );

  ssl_persist u_fbk (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .tick_i(tick_r),
    .cond_i(fbk_exc),
    .delay_i(spd_dly_r),
    .expired_o(fbk_exp)
  );

  // Standstill observation: reference is captured when observation starts.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      standstill_d_r <= 1'b0;
      pos_ref_r <= 16'sh0000;
    end else begin
      standstill_d_r <= ctrl_r[`SSL_CTRL_STANDSTILL];
      if (ctrl_r[`SSL_CTRL_STANDSTILL] && !standstill_d_r) begin
        pos_ref_r <= position_i;
      end
    end
  end

  assign pos_diff = 17'(position_i) - 17'(pos_ref_r);
  assign pos_dev = pos_diff[16] ? 16'(-pos_diff) : pos_diff[15:0];
  assign pos_exc = ctrl_r[`SSL_CTRL_STANDSTILL] && standstill_d_r && (pos_dev > pos_lim_r);

  ssl_persist u_pos (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .tick_i(tick_r),
    .cond_i(pos_exc),
    .delay_i(pos_dly_r),
    .expired_o(pos_exp)
  );

  assign trip_set = cmd_exp || fbk_exp || pos_exp;

  // Latched torque cutoff; only reset or a software clear releases it.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trip_r <= 1'b0;
    end else if (trip_set) begin
      trip_r <= 1'b1;
    end else if (ctrl_r[`SSL_CTRL_TRIP_CLR]) begin
      trip_r <= 1'b0;
    end
  end

  // Safe speed status with hysteresis.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      safe_r <= 1'b0;
    end else if (safe_r) begin
      if (cmd_mag > safe_thr_r || fbk_mag > safe_thr_r) begin
        safe_r <= 1'b0;
      end
    end else if ((32'(cmd_mag) + 32'(safe_hys_r) < 32'(safe_thr_r))
                 && (32'(fbk_mag) + 32'(safe_hys_r) < 32'(safe_thr_r))) begin
      safe_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      torque_cutoff_trip_o <= 1'b0;
      safe_speed_status_out_o <= 1'b0;
      safe_brake_control_out_o <= 1'b0;
    end else begin
      torque_cutoff_trip_o <= trip_r;
      safe_speed_status_out_o <= safe_r;
      safe_brake_control_out_o <= !trip_r;
    end
  end

  assign ev[`SSL_EV_TRIP_SPD] = cmd_exp || fbk_exp;
  assign ev[`SSL_EV_TRIP_POS] = pos_exp;
  assign ev[`SSL_EV_SAFE_FALL] = 1'b0;
  assign ev[`SSL_EV_SAFE_RISE] = safe_r != safe_speed_status_out_o;

  // Sticky status: set wins over write-one-to-clear.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_r <= 4'h0;
    end else if (bus_wr && paddr_i == `SSL_OFS_STAT) begin
      stat_r <= (stat_r & ~pwdata_i[3:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_r & mask_r);
    end
  end

  // Configuration writes.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 4; i++) begin
        spd_lim_r[i] <= `SSL_RST_LIMIT;
        dec_dly_r[i] <= `SSL_RST_DELAY;
      end
      spd_dly_r <= `SSL_RST_DELAY;
      pos_dly_r <= `SSL_RST_DELAY;
      pos_lim_r <= `SSL_RST_LIMIT;
      safe_thr_r <= `SSL_RST_THR;
      safe_hys_r <= `SSL_RST_THR;
      ctrl_r <= 2'h0;
      mask_r <= 4'h0;
    end else begin
      ctrl_r[`SSL_CTRL_TRIP_CLR] <= 1'b0;
      if (bus_wr) begin
        for (int i = 0; i < 4; i++) begin
          if (paddr_i == `SSL_OFS_SPD_LIM1 + 12'(4 * i)) spd_lim_r[i] <= pwdata_i[15:0];
          if (paddr_i == `SSL_OFS_DEC_DLY1 + 12'(4 * i)) dec_dly_r[i] <= pwdata_i[15:0];
        end
        case (paddr_i)
          `SSL_OFS_CTRL: ctrl_r <= pwdata_i[1:0];
          `SSL_OFS_MASK: mask_r <= pwdata_i[3:0];
          `SSL_OFS_SPD_DLY: spd_dly_r <= pwdata_i[15:0];
          `SSL_OFS_POS_DLY: pos_dly_r <= pwdata_i[15:0];
          `SSL_OFS_POS_LIM: pos_lim_r <= pwdata_i[15:0];
          `SSL_OFS_SAFE_THR: safe_thr_r <= pwdata_i[15:0];
          `SSL_OFS_SAFE_HYS: safe_hys_r <= pwdata_i[15:0];
          default: ;
        endcase
      end
    end
  end

  // Read decode.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr_i)
      `SSL_OFS_CTRL: rd_nxt = {31'h0, ctrl_r[0]};
      `SSL_OFS_STAT: rd_nxt = {28'h0, stat_r};
      `SSL_OFS_MASK: rd_nxt = {28'h0, mask_r};
      `SSL_OFS_CMD: rd_nxt = {16'h0, cmd_mag};
      `SSL_OFS_FBK: rd_nxt = {16'h0, fbk_mag};
      `SSL_OFS_POS: rd_nxt = {16'h0, pos_dev};
      `SSL_OFS_SPD_LIM1: rd_nxt = {16'h0, spd_lim_r[0]};
      12'h024: rd_nxt = {16'h0, spd_lim_r[1]};
      12'h028: rd_nxt = {16'h0, spd_lim_r[2]};
      12'h02c: rd_nxt = {16'h0, spd_lim_r[3]};
      `SSL_OFS_DEC_DLY1: rd_nxt = {16'h0, dec_dly_r[0]};
      12'h034: rd_nxt = {16'h0, dec_dly_r[1]};
      12'h038: rd_nxt = {16'h0, dec_dly_r[2]};
      12'h03c: rd_nxt = {16'h0, dec_dly_r[3]};
      `SSL_OFS_SPD_DLY: rd_nxt = {16'h0, spd_dly_r};
      `SSL_OFS_POS_DLY: rd_nxt = {16'h0, pos_dly_r};
      `SSL_OFS_POS_LIM: rd_nxt = {16'h0, pos_lim_r};
      `SSL_OFS_SAFE_THR: rd_nxt = {16'h0, safe_thr_r};
      `SSL_OFS_SAFE_HYS: rd_nxt = {16'h0, safe_hys_r};
      `SSL_OFS_STATE: rd_nxt = {24'h0, safe_r, trip_r, checking, 1'b0, ~limit_request_n_i};
      default: addr_ok = 1'b0;
    endcase
  end

  // APB slave answers in the access cycle; setup registers the reply.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !addr_ok;
      if (bus_rd) begin
        prdata_o <= rd_nxt;
      end
    end
  end

  // Assertions.
  trip_latch_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    trip_r && !ctrl_r[`SSL_CTRL_TRIP_CLR] |=> trip_r)
    else $error("trip released without clear");
  trip_cause_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(trip_r) |-> $past(trip_set))
    else $error("trip without cause");
  cmd_exp_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cmd_exp |=> trip_r)
    else $error("command excess did not trip");
  fbk_exp_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    fbk_exp |=> trip_r)
    else $error("feedback excess did not trip");
  pos_exp_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    pos_exp |-> ##1 trip_r ##1 torque_cutoff_trip_o)
    else $error("position excess did not trip");
  req_end_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    limit_request_n_i[0] && req_st_r[0] == SSL_CHECK |=> req_st_r[0] == SSL_IDLE)
    else $error("check did not end on request high");
  req_start_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_st_r[0] == SSL_IDLE && !limit_request_n_i[0] |=> req_st_r[0] == SSL_DECEL)
    else $error("request low did not start decel");
  lim_min_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_st_r[1] == SSL_CHECK |-> eff_lim <= spd_lim_r[1])
    else $error("effective limit above active limit");
  safe_drop_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    safe_r && (cmd_mag > safe_thr_r || fbk_mag > safe_thr_r) |=> !safe_r)
    else $error("safe status held over threshold");
  safe_rise_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(safe_r) |-> (17'($past(cmd_mag)) + 17'($past(safe_hys_r)) < 17'($past(safe_thr_r)))
      && (17'($past(fbk_mag)) + 17'($past(safe_hys_r)) < 17'($past(safe_thr_r))))
    else $error("safe status rose inside hysteresis");
  timer_clr_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !cmd_exc |=> u_cmd.cnt_r == 16'h0000)
    else $error("persistence timer kept count without excess");
endmodule : ssl_monitor
`default_nettype wire

//--- tb/ssl_drive_model.sv
// Model of the drive path and motion controller that feed the monitor.
// Assumes the bench sets targets; slow mode answers two cycles later.
`timescale 1ns/1ps
`default_nettype none
module ssl_drive_model (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  input wire logic [3:0] req_set_i,
  input wire logic [15:0] cmd_set_i,
  input wire logic [15:0] fbk_set_i,
  input wire logic [15:0] pos_set_i,
  input wire logic brake_out_i,
  output logic [3:0] limit_request_n_o,
  output logic [15:0] speed_cmd_o,
  output logic [15:0] speed_fbk_o,
  output logic [15:0] position_o,
  output logic brake_engaged_o
);
  logic [51:0] s0_r;
  logic [51:0] s1_r;
  logic [51:0] s2_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s0_r <= {4'hf, 48'h0};
      s1_r <= {4'hf, 48'h0};
      s2_r <= {4'hf, 48'h0};
    end else begin
      s0_r <= {req_set_i, cmd_set_i, fbk_set_i, pos_set_i};
      s1_r <= s0_r;
      s2_r <= s1_r;
    end
  end
  assign {limit_request_n_o, speed_cmd_o, speed_fbk_o, position_o} = slow_i ? s2_r : s0_r;
  // The brake engages whenever the safe brake output is low.
  assign brake_engaged_o = !brake_out_i;
endmodule : ssl_drive_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the safe speed limit monitor over APB.
// Assumes the drive model supplies requests, speeds and position.
`timescale 1ns/1ps
`default_nettype none
`include "ssl_params.svh"
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, trip, safe, brake, irq, engaged;
  logic [3:0] req_set = 4'hf;
  logic [3:0] req_n;
  logic [15:0] cmd_set = 16'h0;
  logic [15:0] fbk_set = 16'h0;
  logic [15:0] pos_set = 16'h0;
  logic [15:0] cmd, fbk, pos;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int tc[6] = '{50, 50, 95, 89, 100, 101};
  int tf[6] = '{50, -101, 89, 89, 100, 0};
  logic [5:0] ts = 6'b011001;
  always #20 clk = ~clk;
  ssl_monitor DUT (.sys_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .limit_request_n_i(req_n), .speed_cmd_i(cmd),
    .speed_fbk_i(fbk), .position_i(pos), .torque_cutoff_trip_o(trip),
    .safe_speed_status_out_o(safe), .safe_brake_control_out_o(brake), .irq_o(irq));
  ssl_drive_model drive (.sys_clk_i(clk), .rstn_i(rstn), .slow_i(slow), .req_set_i(req_set),
    .cmd_set_i(cmd_set), .fbk_set_i(fbk_set), .pos_set_i(pos_set), .brake_out_i(brake),
    .limit_request_n_o(req_n), .speed_cmd_o(cmd), .speed_fbk_o(fbk), .position_o(pos),
    .brake_engaged_o(engaged));
  task end_of_test;
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
           output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    chk({31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & m, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd
  task setv(input logic [3:0] r, input logic [15:0] c, input logic [15:0] f,
            input logic [15:0] p);
    req_set <= r;
    cmd_set <= c;
    fbk_set <= f;
    pos_set <= p;
    @(posedge clk);
  endtask : setv
  task stay_trip(input int n, input logic v);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge clk);
      if (trip !== v) bad++;
    end
    chk(bad, 0);
  endtask : stay_trip
  task wait_trip(input int n);
    int k;
    k = 0;
    while (trip !== 1'b1 && k < n) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, trip}, 32'h1);
  endtask : wait_trip
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`SSL_OFS_SPD_LIM1, 32'hffffffff, 32'h0000ffff, 1'b0);
    rd(`SSL_OFS_DEC_DLY1, 32'hffffffff, 32'h00000064, 1'b0);
    rd(12'hffc, 32'hffffffff, 32'h0, 1'b1);
    wr(`SSL_OFS_SAFE_THR, 32'd100);
    wr(`SSL_OFS_SAFE_HYS, 32'd10);
    for (int i = 0; i < 6; i++) begin
      setv(4'hf, 16'(tc[i]), 16'(tf[i]), 16'h0);
      repeat (4) @(posedge clk);
      chk({31'h0, safe}, {31'h0, ts[i]});
    end
    wr(`SSL_OFS_SPD_LIM1, 32'd300);
    wr(`SSL_OFS_SPD_LIM1 + 12'h004, 32'd200);
    wr(`SSL_OFS_DEC_DLY1, 32'd8);
    wr(`SSL_OFS_DEC_DLY1 + 12'h004, 32'd8);
    wr(`SSL_OFS_SPD_DLY, 32'd2);
    setv(4'he, 16'd300, 16'd0, 16'h0);
    stay_trip(400, 1'b0);
    rd(`SSL_OFS_STATE, 32'hffffffff, 32'h00000021, 1'b0);
    rd(`SSL_OFS_CMD, 32'hffffffff, 32'h0000012c, 1'b0);
    setv(4'hc, 16'd250, 16'd0, 16'h0);
    stay_trip(150, 1'b0);
    wait_trip(300);
    chk({31'h0, engaged}, 32'h1);
    setv(4'hf, 16'h0, 16'h0, 16'h0);
    stay_trip(100, 1'b1);
    wr(`SSL_OFS_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(`SSL_OFS_CTRL, 32'h2);
    wr(`SSL_OFS_STAT, 32'hf);
    repeat (2) @(posedge clk);
    chk({30'h0, trip, irq}, 32'h0);
    wr(`SSL_OFS_SPD_LIM1 + 12'h00c, 32'd100);
    wr(`SSL_OFS_DEC_DLY1 + 12'h00c, 32'd2);
    slow <= 1'b1;
    setv(4'h7, 16'h0, 16'h0, 16'h0);
    repeat (100) @(posedge clk);
    repeat (5) begin
      setv(4'h7, 16'h0, 16'd150, 16'h0);
      repeat (18) @(posedge clk);
      setv(4'h7, 16'h0, 16'h0, 16'h0);
      repeat (20) @(posedge clk);
    end
    chk({31'h0, trip}, 32'h0);
    setv(4'h7, 16'h0, 16'hff6a, 16'h0);
    wait_trip(200);
    rd(`SSL_OFS_FBK, 32'hffffffff, 32'h00000096, 1'b0);
    setv(4'hf, 16'h0, 16'h0, 16'h0);
    repeat (4) @(posedge clk);
    wr(`SSL_OFS_CTRL, 32'h2);
    slow <= 1'b0;
    wr(`SSL_OFS_POS_LIM, 32'd5);
    wr(`SSL_OFS_POS_DLY, 32'd8);
    wr(`SSL_OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    setv(4'hf, 16'h0, 16'h0, 16'd10);
    stay_trip(150, 1'b0);
    wait_trip(300);
    rd(`SSL_OFS_STAT, 32'h2, 32'h2, 1'b0);
    rd(`SSL_OFS_POS, 32'hffffffff, 32'h0000000a, 1'b0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
